// file: rtl/cbk_pkg.sv
// Function
// - mode bit0 data/program, bit1 mixed mode
// - mode bit2 enables digital loop-back
// - mode bit3 enables serial loop-back
// - mode bits 6..4 cascade device count
// - clocking bits 1..0 rate code
// - clocking bits 3..2 serial clock divider
// - clocking bits 6..4 master clock divider
// - clocking bit7 enables control echo
// - power bit0 global power-up
// - power bits 3,4,5 converter/reference power
// - power bit6 enables reference output pin
// - gain bits 2..0 input, 6..4 output
// - gain bit3 holds modulator in reset
// - advance bits 4..0 load advance value
// - advance bit5 bypasses output interpolator
// - analog bit5 selects single-ended input
// - analog bit6 inverts input signal
// - analog bit7 enables analog loop-back
// - writes only in program or mixed mode
// - every serial transfer is 16 bits
// - control word field layout fixed
// - nonzero device address decremented, passed on
// - reset clears all registers to zero
// - soft reset bit acts like pin, 4 cycles
package cbk_pkg;

  // ----------------------------------------------------------------
  // control word layout
  // ----------------------------------------------------------------
  localparam int WORD_W    = 16;
  localparam int CTL_BIT   = 15;
  localparam int RW_BIT    = 14;
  localparam int DEV_MSB   = 13;
  localparam int DEV_LSB   = 11;
  localparam int RADDR_MSB = 10;
  localparam int RADDR_LSB = 8;
  localparam int DATA_MSB  = 7;

  // ----------------------------------------------------------------
  // register indices
  // ----------------------------------------------------------------
  localparam int       NUM_REGS     = 6;
  localparam logic [2:0] REG_MODE   = 3'h0;
  localparam logic [2:0] REG_CLOCK  = 3'h1;
  localparam logic [2:0] REG_POWER  = 3'h2;
  localparam logic [2:0] REG_GAIN   = 3'h3;
  localparam logic [2:0] REG_ADV    = 3'h4;
  localparam logic [2:0] REG_ANALOG = 3'h5;
  localparam logic [7:0] REG_RESET  = 8'h00;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int MODE_SEL_BIT   = 0;
  localparam int MIXED_BIT      = 1;
  localparam int DIGLOOP_BIT    = 2;
  localparam int SERLOOP_BIT    = 3;
  localparam int CASCADE_LSB    = 4;
  localparam int CASCADE_MSB    = 6;
  localparam int SOFT_RESET_BIT = 7;
  localparam int RATE_LSB       = 0;
  localparam int RATE_MSB       = 1;
  localparam int SCD_LSB        = 2;
  localparam int SCD_MSB        = 3;
  localparam int MCD_LSB        = 4;
  localparam int MCD_MSB        = 6;
  localparam int ECHO_BIT       = 7;
  localparam int PWR_ALL_BIT    = 0;
  localparam int PWR_IN_BIT     = 3;
  localparam int PWR_OUT_BIT    = 4;
  localparam int PWR_REF_BIT    = 5;
  localparam int REF_PIN_BIT    = 6;
  localparam int IGAIN_LSB      = 0;
  localparam int IGAIN_MSB      = 2;
  localparam int MODRST_BIT     = 3;
  localparam int OGAIN_LSB      = 4;
  localparam int OGAIN_MSB      = 6;
  localparam int MUTE_BIT       = 7;
  localparam int ADV_LSB        = 0;
  localparam int ADV_MSB        = 4;
  localparam int BYPASS_BIT     = 5;
  localparam int SINGLE_BIT     = 5;
  localparam int INVERT_BIT     = 6;
  localparam int ANALOOP_BIT    = 7;

  // ----------------------------------------------------------------
  // storable bits per register (reserved and self-clearing read zero)
  // ----------------------------------------------------------------
  localparam logic [7:0] MASK_MODE   = 8'h7F;
  localparam logic [7:0] MASK_CLOCK  = 8'hFF;
  localparam logic [7:0] MASK_POWER  = 8'h79;
  localparam logic [7:0] MASK_GAIN   = 8'hFF;
  localparam logic [7:0] MASK_ADV    = 8'h3F;
  localparam logic [7:0] MASK_ANALOG = 8'hE0;

  // ----------------------------------------------------------------
  // timing counts
  // ----------------------------------------------------------------
  localparam logic [2:0] RESET_CYCLES   = 3'h4;
  localparam logic [7:0] SCLK_HALF_MIN  = 8'h04;
  localparam logic [4:0] BIT_LAST       = 5'h0F;

endpackage : cbk_pkg

// file: rtl/cbk_sclk_gen.sv
`timescale 1ns/100ps
module cbk_sclk_gen (
  // clock and reset
  input  wire logic       mclk,
  input  wire logic       rst_n,
  // divider select
  input  wire logic [1:0] div_code,
  // serial clock and edge strobes
  output logic            sclk,
  output logic            sclk_rise,
  output logic            sclk_fall
);

  logic [7:0] cnt;
  logic [7:0] next_cnt;
  logic       next_sclk;
  logic [7:0] half;

  // ----------------------------------------------------------------
  // half period: code 3 fastest; never below the synchroniser margin
  // ----------------------------------------------------------------
  always_comb begin
    half      = 8'(cbk_pkg::SCLK_HALF_MIN << (2'h3 - div_code));
    next_cnt  = cnt + 8'h01;
    next_sclk = sclk;
    if (cnt >= half - 8'h01) begin
      next_cnt  = 8'h00;
      next_sclk = ~sclk;
    end
  end

  // strobes mark the mclk cycle just before sclk toggles
  assign sclk_rise = (next_sclk == 1'b1) && (sclk == 1'b0);
  assign sclk_fall = (next_sclk == 1'b0) && (sclk == 1'b1);

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      cnt  <= 8'h00;
      sclk <= 1'b0;
    end else begin
      cnt  <= next_cnt;
      sclk <= next_sclk;
    end
  end

endmodule // cbk_sclk_gen

// file: rtl/cbk_serial_tx.sv
`timescale 1ns/100ps
module cbk_serial_tx (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_n,
  // serial clock edges
  input  wire logic        sclk_fall,
  // word to send
  input  wire logic        load,
  input  wire logic [15:0] word,
  output logic             busy,
  // serial pins
  output logic             sdo,
  output logic             frame_sync
);

  typedef enum logic [1:0] {TX_IDLE, TX_SYNC, TX_SHIFT} cbk_tx_state_type;

  cbk_tx_state_type state, next_state;
  logic [15:0] shreg, next_shreg;
  logic [4:0]  cnt, next_cnt;
  logic        pend, next_pend;
  logic        next_sdo, next_fs;

  assign busy = pend || (state != TX_IDLE);

  // ----------------------------------------------------------------
  // frame sync one bit ahead, then 16 bits msb first on falling edges
  // ----------------------------------------------------------------
  always_comb begin
    next_state = state;
    next_shreg = shreg;
    next_cnt   = cnt;
    next_pend  = pend;
    next_sdo   = sdo;
    next_fs    = frame_sync;
    if (load && !busy) begin
      next_shreg = word;
      next_pend  = 1'b1;
    end
    if (sclk_fall) begin
      case (state)
        TX_IDLE: begin
          next_sdo = 1'b0;
          if (pend) begin
            next_fs    = 1'b1;
            next_pend  = 1'b0;
            next_state = TX_SYNC;
          end
        end
        TX_SYNC: begin
          next_fs    = 1'b0;
          next_sdo   = shreg[15];
          next_shreg = {shreg[14:0], 1'b0};
          next_cnt   = 5'h00;
          next_state = TX_SHIFT;
        end
        default: begin
          if (cnt == cbk_pkg::BIT_LAST) begin
            next_sdo   = 1'b0;
            next_state = TX_IDLE;
          end else begin
            next_sdo   = shreg[15];
            next_shreg = {shreg[14:0], 1'b0};
            next_cnt   = cnt + 5'h01;
          end
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      state      <= TX_IDLE;
      shreg      <= 16'h0000;
      cnt        <= 5'h00;
      pend       <= 1'b0;
      sdo        <= 1'b0;
      frame_sync <= 1'b0;
    end else begin
      state      <= next_state;
      shreg      <= next_shreg;
      cnt        <= next_cnt;
      pend       <= next_pend;
      sdo        <= next_sdo;
      frame_sync <= next_fs;
    end
  end

endmodule // cbk_serial_tx

// file: rtl/cbk_control_regs.sv
`timescale 1ns/100ps
module cbk_control_regs (
  // clock and reset
  input  wire logic       mclk,
  input  wire logic       rst_n,
  // serial port
  output logic            sclk,
  input  wire logic       sdi,
  input  wire logic       input_frame_sync,
  output logic            sdo,
  output logic            output_frame_sync,
  // mode controls
  output logic            mode_select_bit,
  output logic            mixed_mode_enable,
  output logic            digital_loopback_enable,
  output logic            serial_loopback_enable,
  output logic [2:0]      cascade_count,
  output logic            reset_busy,
  // clocking controls
  output logic [1:0]      rate_code,
  output logic [1:0]      serial_clock_div,
  output logic [2:0]      master_div,
  output logic            control_echo_enable,
  // power controls
  output logic            global_power_up,
  output logic            input_converter_on,
  output logic            output_converter_on,
  output logic            reference_on,
  output logic            reference_output_enable,
  // gain and mute
  output logic [2:0]      input_gain,
  output logic            modulator_reset,
  output logic [2:0]      output_gain,
  output logic            output_mute,
  // output converter options
  output logic [4:0]      advance,
  output logic            interpolator_bypass,
  // analog options
  output logic            single_ended_enable,
  output logic            input_invert,
  output logic            analog_loopback_enable
);

  typedef enum logic {RX_IDLE, RX_SHIFT} cbk_rx_state_type;

  // ----------------------------------------------------------------
  // storage mask per register index
  // ----------------------------------------------------------------
  function automatic logic [7:0] cbk_mask(input logic [2:0] idx);
    logic [7:0] m;
    m = 8'h00;
    if (idx == cbk_pkg::REG_MODE) begin
      m = cbk_pkg::MASK_MODE;
    end else if (idx == cbk_pkg::REG_CLOCK) begin
      m = cbk_pkg::MASK_CLOCK;
    end else if (idx == cbk_pkg::REG_POWER) begin
      m = cbk_pkg::MASK_POWER;
    end else if (idx == cbk_pkg::REG_GAIN) begin
      m = cbk_pkg::MASK_GAIN;
    end else if (idx == cbk_pkg::REG_ADV) begin
      m = cbk_pkg::MASK_ADV;
    end else if (idx == cbk_pkg::REG_ANALOG) begin
      m = cbk_pkg::MASK_ANALOG;
    end
    return m;
  endfunction

  logic [7:0]  regs      [cbk_pkg::NUM_REGS];
  logic [7:0]  next_regs [cbk_pkg::NUM_REGS];
  logic [2:0]  rst_cnt, next_rst_cnt;
  logic        sdi_meta, sdi_sync, fs_meta, fs_sync;
  logic        sclk_rise, sclk_fall;
  cbk_rx_state_type rx_state, next_rx_state;
  logic [15:0] rx_shreg, next_rx_shreg;
  logic [4:0]  rx_cnt, next_rx_cnt;
  logic        rx_valid, next_rx_valid;
  logic        tx_load;
  logic [15:0] tx_word;
  logic        soft_trig;
  logic        in_reset;
  logic        ctl_word, write_ok;
  logic [2:0]  dev_addr, reg_addr;
  logic [7:0]  wdata;

  // ----------------------------------------------------------------
  // serial clock and transmitter
  // ----------------------------------------------------------------
  cbk_sclk_gen i_cbk_sclk_gen (
    .mclk      (mclk),
    .rst_n     (rst_n),
    .div_code  (regs[cbk_pkg::REG_CLOCK][cbk_pkg::SCD_MSB:cbk_pkg::SCD_LSB]),
    .sclk      (sclk),
    .sclk_rise (sclk_rise),
    .sclk_fall (sclk_fall)
  );

  cbk_serial_tx i_cbk_serial_tx (
    .mclk       (mclk),
    .rst_n      (rst_n),
    .sclk_fall  (sclk_fall),
    .load       (tx_load),
    .word       (tx_word),
    .busy       (),
    .sdo        (sdo),
    .frame_sync (output_frame_sync)
  );

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      sdi_meta <= 1'b0;
      sdi_sync <= 1'b0;
      fs_meta  <= 1'b0;
      fs_sync  <= 1'b0;
    end else begin
      sdi_meta <= sdi;
      sdi_sync <= sdi_meta;
      fs_meta  <= input_frame_sync;
      fs_sync  <= fs_meta;
    end
  end

  // ----------------------------------------------------------------
  // receiver: frame sync one bit early, back-to-back frames allowed
  // ----------------------------------------------------------------
  always_comb begin
    next_rx_state = rx_state;
    next_rx_shreg = rx_shreg;
    next_rx_cnt   = rx_cnt;
    next_rx_valid = 1'b0;
    if (sclk_rise) begin
      case (rx_state)
        RX_IDLE: begin
          if (fs_sync) begin
            next_rx_state = RX_SHIFT;
            next_rx_cnt   = 5'h00;
          end
        end
        default: begin
          next_rx_shreg = {rx_shreg[14:0], sdi_sync};
          next_rx_cnt   = rx_cnt + 5'h01;
          if (rx_cnt == cbk_pkg::BIT_LAST) begin
            next_rx_valid = 1'b1;
            next_rx_cnt   = 5'h00;
            if (!fs_sync) begin
              next_rx_state = RX_IDLE;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rx_state <= RX_IDLE;
      rx_shreg <= 16'h0000;
      rx_cnt   <= 5'h00;
      rx_valid <= 1'b0;
    end else begin
      rx_state <= next_rx_state;
      rx_shreg <= next_rx_shreg;
      rx_cnt   <= next_rx_cnt;
      rx_valid <= next_rx_valid;
    end
  end

  // ----------------------------------------------------------------
  // word decode
  // ----------------------------------------------------------------
  // field split
  assign dev_addr = rx_shreg[cbk_pkg::DEV_MSB:cbk_pkg::DEV_LSB];
  assign reg_addr = rx_shreg[cbk_pkg::RADDR_MSB:cbk_pkg::RADDR_LSB];
  assign wdata    = rx_shreg[cbk_pkg::DATA_MSB:0];
  assign in_reset = (rst_cnt != 3'h0);

  // control words exist only in program and mixed modes
  assign ctl_word = rx_valid && !in_reset && rx_shreg[cbk_pkg::CTL_BIT]
                    && (!mode_select_bit || mixed_mode_enable);
  // diagnostic and plain data modes lock the registers unless mixed mode is set
  assign write_ok = mixed_mode_enable
                    || (!mode_select_bit && !digital_loopback_enable
                        && !serial_loopback_enable);

  // ----------------------------------------------------------------
  // register writes, reads and forwarding
  // ----------------------------------------------------------------
  always_comb begin
    for (int i = 0; i < cbk_pkg::NUM_REGS; i++) begin
      next_regs[i] = regs[i];
    end
    soft_trig = 1'b0;
    tx_load   = 1'b0;
    tx_word   = rx_shreg;
    if (ctl_word) begin
      if (dev_addr != 3'h0) begin
        tx_load = 1'b1;
        tx_word = {rx_shreg[15:14], 3'(dev_addr - 3'h1), rx_shreg[10:0]};
      end else if (rx_shreg[cbk_pkg::RW_BIT]) begin
        // readback returns the word with the register contents
        if (reg_addr < 3'(cbk_pkg::NUM_REGS)) begin
          tx_load = 1'b1;
          tx_word = {rx_shreg[15:8], regs[reg_addr]};
        end
      end else if (write_ok && reg_addr < 3'(cbk_pkg::NUM_REGS)) begin
        // reserved bits dropped; host keeps them zero anyway
        next_regs[reg_addr] = wdata & cbk_mask(reg_addr);
        tx_load = control_echo_enable;
        if (reg_addr == cbk_pkg::REG_MODE && wdata[cbk_pkg::SOFT_RESET_BIT]) begin
          soft_trig = 1'b1;
        end
      end
    end else if (rx_valid && !in_reset && serial_loopback_enable) begin
      // serial loop-back returns the word unchanged
      tx_load = 1'b1;
    end
    if (soft_trig || in_reset) begin
      for (int i = 0; i < cbk_pkg::NUM_REGS; i++) begin
        next_regs[i] = cbk_pkg::REG_RESET;
      end
    end
  end

  // four-cycle reset window after pin or soft reset
  always_comb begin
    next_rst_cnt = rst_cnt;
    if (soft_trig) begin
      next_rst_cnt = cbk_pkg::RESET_CYCLES;
    end else if (in_reset) begin
      next_rst_cnt = rst_cnt - 3'h1;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      for (int i = 0; i < cbk_pkg::NUM_REGS; i++) begin
        regs[i] <= cbk_pkg::REG_RESET;
      end
      rst_cnt <= cbk_pkg::RESET_CYCLES;
    end else begin
      for (int i = 0; i < cbk_pkg::NUM_REGS; i++) begin
        regs[i] <= next_regs[i];
      end
      rst_cnt <= next_rst_cnt;
    end
  end

  // ----------------------------------------------------------------
  // field outputs
  // ----------------------------------------------------------------
  assign reset_busy              = in_reset;
  assign mode_select_bit         = regs[cbk_pkg::REG_MODE][cbk_pkg::MODE_SEL_BIT];
  assign mixed_mode_enable       = regs[cbk_pkg::REG_MODE][cbk_pkg::MIXED_BIT];
  assign digital_loopback_enable = regs[cbk_pkg::REG_MODE][cbk_pkg::DIGLOOP_BIT];
  assign serial_loopback_enable  = regs[cbk_pkg::REG_MODE][cbk_pkg::SERLOOP_BIT];
  assign cascade_count = regs[cbk_pkg::REG_MODE][cbk_pkg::CASCADE_MSB:cbk_pkg::CASCADE_LSB];
  assign rate_code     = regs[cbk_pkg::REG_CLOCK][cbk_pkg::RATE_MSB:cbk_pkg::RATE_LSB];
  // serial clock divider code, also steers sclk
  assign serial_clock_div = regs[cbk_pkg::REG_CLOCK][cbk_pkg::SCD_MSB:cbk_pkg::SCD_LSB];
  assign master_div    = regs[cbk_pkg::REG_CLOCK][cbk_pkg::MCD_MSB:cbk_pkg::MCD_LSB];
  assign control_echo_enable = regs[cbk_pkg::REG_CLOCK][cbk_pkg::ECHO_BIT];
  // global power-up overrides the converter and reference power enables, not the reference pin enable
  assign global_power_up     = regs[cbk_pkg::REG_POWER][cbk_pkg::PWR_ALL_BIT];
  assign input_converter_on  = global_power_up || regs[cbk_pkg::REG_POWER][cbk_pkg::PWR_IN_BIT];
  assign output_converter_on = global_power_up || regs[cbk_pkg::REG_POWER][cbk_pkg::PWR_OUT_BIT];
  assign reference_on        = global_power_up || regs[cbk_pkg::REG_POWER][cbk_pkg::PWR_REF_BIT];
  assign reference_output_enable = regs[cbk_pkg::REG_POWER][cbk_pkg::REF_PIN_BIT];
  assign input_gain    = regs[cbk_pkg::REG_GAIN][cbk_pkg::IGAIN_MSB:cbk_pkg::IGAIN_LSB];
  assign output_gain   = regs[cbk_pkg::REG_GAIN][cbk_pkg::OGAIN_MSB:cbk_pkg::OGAIN_LSB];
  assign modulator_reset = regs[cbk_pkg::REG_GAIN][cbk_pkg::MODRST_BIT];
  assign output_mute   = regs[cbk_pkg::REG_GAIN][cbk_pkg::MUTE_BIT];
  assign advance       = regs[cbk_pkg::REG_ADV][cbk_pkg::ADV_MSB:cbk_pkg::ADV_LSB];
  assign interpolator_bypass = regs[cbk_pkg::REG_ADV][cbk_pkg::BYPASS_BIT];
  assign single_ended_enable = regs[cbk_pkg::REG_ANALOG][cbk_pkg::SINGLE_BIT];
  assign input_invert        = regs[cbk_pkg::REG_ANALOG][cbk_pkg::INVERT_BIT];
  assign analog_loopback_enable = regs[cbk_pkg::REG_ANALOG][cbk_pkg::ANALOOP_BIT];

endmodule // cbk_control_regs

// file: testbench/cbk_control_regs_properties.sv
`timescale 1ns/100ps
module cbk_control_regs_properties (
  // clock and reset
  input wire logic       mclk,
  input wire logic       rst_n,
  // serial outputs
  input wire logic       sclk,
  input wire logic       sdo,
  // control outputs
  input wire logic       mode_select_bit,
  input wire logic       mixed_mode_enable,
  input wire logic [2:0] cascade_count,
  input wire logic       reset_busy,
  input wire logic [1:0] rate_code,
  input wire logic       global_power_up,
  input wire logic       input_converter_on,
  input wire logic       output_converter_on,
  input wire logic       reference_on,
  input wire logic [2:0] input_gain,
  input wire logic [2:0] output_gain
);
  // fields from the mode, clocking and gain registers, so a stray write to those fields shows up
  logic [11:0] v;
  assign v = {rate_code, input_gain, output_gain, cascade_count, mode_select_bit};
  default clocking cb_mclk @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  // ----------
  // properties
  // ----------
  property p_reset_clear;
    $rose(rst_n) |-> v == 12'h000 && !sclk;
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("not clear after reset");
  property p_release_busy;
    $rose(rst_n) |-> reset_busy [*4];
  endproperty
  a_release_busy: assert property (p_release_busy) else $error("reset window short");
  property p_soft_len;
    $rose(reset_busy) |-> reset_busy [*4] ##1 !reset_busy;
  endproperty
  a_soft_len: assert property (p_soft_len) else $error("soft reset not four cycles");
  property p_held;
    reset_busy && $past(reset_busy) |-> v == 12'h000;
  endproperty
  a_held: assert property (p_held) else $error("registers not held in reset");
  property p_lock;
    mode_select_bit && !mixed_mode_enable |=> $stable(v);
  endproperty
  a_lock: assert property (p_lock) else $error("write taken in data mode");
  property p_power;
    global_power_up |-> input_converter_on && output_converter_on && reference_on;
  endproperty
  a_power: assert property (p_power) else $error("global power-up ignored");
  property p_sdo_fall;
    $changed(sdo) |-> !sclk;
  endproperty
  a_sdo_fall: assert property (p_sdo_fall) else $error("serial out moved while high");
  property p_sclk_half;
    $changed(sclk) |=> $stable(sclk) [*3];
  endproperty
  a_sclk_half: assert property (p_sclk_half) else $error("serial clock too fast");
  c_soft: cover property ($rose(reset_busy));
  c_data: cover property (mode_select_bit && !mixed_mode_enable);
  c_power: cover property (global_power_up);
endmodule // cbk_control_regs_properties

// file: testbench/cbk_host_model.sv
`timescale 1ns/100ps
module cbk_host_model (
  // device clocks and serial output
  input  wire logic mclk,
  input  wire logic sclk,
  input  wire logic sdo,
  input  wire logic output_frame_sync,
  // host transmit
  output logic      sdi,
  output logic      input_frame_sync
);
  logic [15:0] rx_word = 16'h0000;
  int          rx_cnt = 0;
  int          rx_bit = 0;
  initial begin
    sdi = 1'b0;
    input_frame_sync = 1'b0;
  end
  task automatic send(input logic [15:0] w);
    @(negedge sclk) @(negedge mclk);
    input_frame_sync = 1'b1;
    for (int i = 15; i >= 0; i--) begin
      @(negedge sclk) @(negedge mclk);
      input_frame_sync = 1'b0;
      sdi = w[i];
    end
    @(negedge sclk) @(negedge mclk);
    sdi = ~sdi; // released line must not look like a held bit
    repeat (4) @(negedge sclk);
  endtask
  // receive, device moves sdo on falls so sample on rises
  always @(posedge sclk) begin
    if (rx_bit > 0) begin
      rx_word = {rx_word[14:0], sdo};
      rx_bit--;
      if (rx_bit == 0) rx_cnt++;
    end
    if (output_frame_sync) rx_bit = 16;
  end
endmodule // cbk_host_model

// file: testbench/test_codec_control_register_bank.sv
`timescale 1ns/100ps
module test_codec_control_register_bank;
  logic       mclk = 1'b0;
  logic       rst_n = 1'b0;
  logic       sclk, sdi, input_frame_sync, sdo, output_frame_sync, reset_busy;
  logic       mode_select_bit, mixed_mode_enable, digital_loopback_enable;
  logic       serial_loopback_enable, control_echo_enable, global_power_up;
  logic       input_converter_on, output_converter_on, reference_on, reference_output_enable;
  logic       modulator_reset, output_mute, interpolator_bypass, single_ended_enable;
  logic       input_invert, analog_loopback_enable;
  logic [2:0] cascade_count, master_div, input_gain, output_gain;
  logic [1:0] rate_code, serial_clock_div;
  logic [4:0] advance;
  int         num_errors = 0;
  int         num_checks = 0;
  int         busy_cnt = 0;
  cbk_control_regs i_cbk_control_regs (
    .mclk, .rst_n, .sclk, .sdi, .input_frame_sync, .sdo, .output_frame_sync,
    .mode_select_bit, .mixed_mode_enable, .digital_loopback_enable, .serial_loopback_enable,
    .cascade_count, .reset_busy, .rate_code, .serial_clock_div, .master_div,
    .control_echo_enable, .global_power_up, .input_converter_on, .output_converter_on,
    .reference_on, .reference_output_enable, .input_gain, .modulator_reset, .output_gain,
    .output_mute, .advance, .interpolator_bypass, .single_ended_enable, .input_invert,
    .analog_loopback_enable
  );
  cbk_host_model i_cbk_host_model (
    .mclk, .sclk, .sdo, .output_frame_sync, .sdi, .input_frame_sync
  );
  always #5 mclk = ~mclk;
  // count on the falling edge, where the busy flag has settled
  always @(negedge mclk) if (reset_busy === 1'b1) busy_cnt++;
  // ----------
  // helpers
  // ----------
  task automatic chk(input logic [15:0] got, exp, input string msg);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask
  // rebuild a register image from the output levels
  function automatic logic [7:0] view(input logic [2:0] r);
    case (r)
      3'h0: view = {1'b0, cascade_count, serial_loopback_enable, digital_loopback_enable,
                    mixed_mode_enable, mode_select_bit};
      3'h1: view = {control_echo_enable, master_div, serial_clock_div, rate_code};
      3'h2: view = {1'b0, reference_output_enable, reference_on, output_converter_on,
                    input_converter_on, 2'b00, global_power_up};
      3'h3: view = {output_mute, output_gain, modulator_reset, input_gain};
      3'h4: view = {2'b00, interpolator_bypass, advance};
      default: view = {analog_loopback_enable, input_invert, single_ended_enable, 5'h00};
    endcase
  endfunction
  task automatic wr(input logic [2:0] r, input logic [7:0] d);
    i_cbk_host_model.send({2'b10, 3'h0, r, d});
  endtask
  task automatic reply(input logic [15:0] w, exp);
    int n0;
    repeat (40) @(negedge sclk); // let any earlier echo drain first
    n0 = i_cbk_host_model.rx_cnt;
    i_cbk_host_model.send(w);
    for (int i = 0; i < 60 && i_cbk_host_model.rx_cnt == n0; i++) @(negedge sclk);
    chk(i_cbk_host_model.rx_word, exp, "reply word");
  endtask
  task automatic do_reset;
    rst_n = 1'b0;
    repeat (4) @(negedge mclk);
    rst_n = 1'b1;
    @(negedge mclk);
    chk(reset_busy, 1'b1, "busy after reset");
    repeat (8) @(negedge mclk);
    for (int r = 0; r < 6; r++) chk(view(3'(r)), 8'h00, "reset value");
  endtask
  // ----------
  // scenarios
  // ----------
  // reserved bits written zero
  task automatic t_fields;
    logic [19:0] tbl [12] = '{20'h10C0C, 20'h27878, 20'h3A5A5, 20'h35A5A, 20'h43F3F,
                              20'h41515, 20'h5E0E0, 20'h5A0A0, 20'h13D3D, 20'h20139,
                              20'h07070, 20'h03232};
    foreach (tbl[i]) begin
      wr(tbl[i][18:16], tbl[i][15:8]);
      chk(view(tbl[i][18:16]), tbl[i][7:0], "field");
    end
  endtask
  task automatic t_reply;
    wr(cbk_pkg::REG_CLOCK, 8'hBD);
    reply(16'h8333, 16'h8333);
    wr(cbk_pkg::REG_CLOCK, 8'h3D);
    reply(16'hC300, 16'hC333);
    reply(16'h9B11, 16'h9311);
    chk(view(cbk_pkg::REG_GAIN), 8'h33, "forwarded word kept");
  endtask
  task automatic t_soft;
    busy_cnt = 0;
    wr(cbk_pkg::REG_MODE, 8'h80);
    chk(16'(busy_cnt), 16'h0004, "soft reset length");
    for (int r = 0; r < 6; r++) chk(view(3'(r)), 8'h00, "soft reset value");
  endtask
  task automatic t_lock;
    wr(cbk_pkg::REG_CLOCK, 8'h0C);
    wr(cbk_pkg::REG_MODE, 8'h03);
    wr(cbk_pkg::REG_GAIN, 8'h44);
    chk(view(cbk_pkg::REG_GAIN), 8'h44, "mixed mode write");
    wr(cbk_pkg::REG_MODE, 8'h01);
    wr(cbk_pkg::REG_GAIN, 8'h55);
    chk(view(cbk_pkg::REG_GAIN), 8'h44, "data mode write");
    do_reset;
    wr(cbk_pkg::REG_MODE, 8'h7C);
    chk(view(cbk_pkg::REG_MODE), 8'h7C, "loop-back fields");
  endtask
  task automatic close_out;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    do_reset;
    t_fields;
    t_reply;
    t_soft;
    t_lock;
    close_out;
  end
  // about four times the expected run, which is near 10k cycles
  initial begin
    #400000;
    num_errors++;
    close_out;
  end
endmodule // test_codec_control_register_bank
bind cbk_control_regs cbk_control_regs_properties i_cbk_control_regs_properties (
  .mclk, .rst_n, .sclk, .sdo, .mode_select_bit, .mixed_mode_enable, .cascade_count,
  .reset_busy, .rate_code, .global_power_up, .input_converter_on, .output_converter_on,
  .reference_on, .input_gain, .output_gain
);
